// ### verilog/edm_external_bus_interface.sv
// Purpose: Steers external moves to on-chip RAM, the FIFO window or the off-chip bus
// Assumes: Inputs synchronous to mclk; FIFO answers within FIFO_WAIT cycles
// Notes: Requests are taken only while idle
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - FIFO enable maps FIFO RAM at 0x0400-0x07FF
// - Window hides ordinary memory at those addresses
// - Bit 4 chooses multiplexed or separate bus
// - Mode 00 keeps all on-chip, wrapping
// - 8-bit address is page plus index
// - Split modes: low on-chip, high off-chip
// - Split no-bank 8-bit leaves high lines undriven
// - Bank mode 8-bit drives page on high lines
// - 16-bit off-chip drives all sixteen lines
// - Mode 11 all off-chip, page ignored
// - Latch strobe high and low width 1-4
// - Address on shared bus while latch strobe high
// - Off-chip move lasts parameters plus four
// - Multiplexed access adds latch phase, minimum six
// - Timing register resets to maximum delays
// - Config bits 7 and 5 read zero
// - Setup 0-3, strobe 1-16, hold 0-3
// - Pins driven only during off-chip move
module edm_external_bus_interface (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Special function register port
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrWrData,
	output logic [7:0] sfrRdData,
	// CPU external move
	input wire logic movReq,
	input wire logic movWrite,
	input wire logic movWide,
	input wire logic [15:0] dataPtr,
	input wire logic [7:0] indexReg,
	input wire logic [7:0] movWrData,
	output logic movDone,
	output logic movBusy,
	output logic [7:0] movRdData,
	// USB FIFO RAM window
	output logic fifoReq,
	output logic fifoWe,
	output logic [9:0] fifoAddr,
	output logic [7:0] fifoWrData,
	input wire logic [7:0] fifoRdData,
	// Off-chip bus pins
	output logic [7:0] addrHiOut,
	output logic addrHiOe,
	output logic [7:0] addrLoOut,
	output logic addrLoOe,
	output logic [7:0] busOut,
	output logic busOe,
	input wire logic [7:0] busIn,
	output logic rdStrobeN,
	output logic wrStrobeN,
	output logic aleOut,
	output logic emifOwn
);
	import edm_pkg::*;

	typedef struct packed {
		edm_state_t st;
		logic [3:0] cnt;
		logic fifoEn;
		logic muxSel;
		logic [1:0] mode;
		logic [1:0] aleW;
		logic [7:0] tim;
		logic [7:0] page;
		logic [7:0] sfrRd;
		logic [15:0] addr;
		logic wr;
		logic hiDrive;
		logic [7:0] wdata;
		logic [7:0] rdData;
		logic own, ale, rdN, wrN, hiOe, loOe, busOe, done, ramReq, fifoReq, busy;
		logic [7:0] busOut;
	} edm_regs_t;

	edm_regs_t s_ff, nxt_s;
	edm_ram_if ram ();
	logic [15:0] effAddr;
	logic fifoHit, offHit, muxed, pre;
	logic [1:0] eas, eah;
	logic [3:0] ewr;
	edm_state_t setupSt;
	logic [3:0] setupCnt;

	////////////////////////////////////////////////////////////////////////
	assign effAddr = movWide ? dataPtr : {s_ff.page, indexReg};
	assign fifoHit = s_ff.fifoEn && (effAddr[15:10] == FIFO_PAGE_HI);
	assign muxed = !s_ff.muxSel;
	assign eas = s_ff.tim[TIM_EAS_LSB +: 2];
	assign ewr = s_ff.tim[TIM_EWR_LSB +: 4];
	assign eah = s_ff.tim[TIM_EAH_LSB +: 2];

	always_comb begin
		case (s_ff.mode)
			MODE_ONCHIP: offHit = 1'b0;
			MODE_SPLIT, MODE_BANK: offHit = (effAddr[15:RAM_AW] != 4'h0);
			default: offHit = 1'b1;
		endcase
	end

	// Setup is skipped when its count is zero
	always_comb begin
		if (eas != 2'b00) begin
			setupSt = ST_SETUP;
			setupCnt = {2'b00, eas - 2'b01};
		end else begin
			setupSt = ST_STROBE;
			setupCnt = ewr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_s = s_ff;
		if (sfrWrEn) begin
			case (sfrAddr)
				CFG_ADDR: begin
					nxt_s.fifoEn = sfrWrData[CFG_FIFO_BIT];
					nxt_s.muxSel = sfrWrData[CFG_MUX_BIT];
					nxt_s.mode = sfrWrData[CFG_MODE_LSB +: 2];
					nxt_s.aleW = sfrWrData[CFG_ALE_LSB +: 2];
				end
				TIM_ADDR: nxt_s.tim = sfrWrData;
				PAGE_ADDR: nxt_s.page = sfrWrData;
				default: ;
			endcase
		end
		if (sfrRdEn) begin
			case (sfrAddr)
				CFG_ADDR: nxt_s.sfrRd = {1'b0, s_ff.fifoEn, 1'b0, s_ff.muxSel, s_ff.mode, s_ff.aleW};
				TIM_ADDR: nxt_s.sfrRd = s_ff.tim;
				PAGE_ADDR: nxt_s.sfrRd = s_ff.page;
				default: nxt_s.sfrRd = 8'h00;
			endcase
		end
		case (s_ff.st)
			ST_IDLE: begin
				if (movReq) begin
					nxt_s.addr = effAddr;
					nxt_s.wr = movWrite;
					nxt_s.wdata = movWrData;
					nxt_s.hiDrive = movWide || (s_ff.mode == MODE_BANK);
					if (fifoHit) begin
						nxt_s.st = ST_FIFO;
						nxt_s.cnt = FIFO_WAIT - 4'h1;
					end else if (!offHit) begin
						nxt_s.st = ST_ONCHIP;
					end else begin
						nxt_s.st = ST_ADDR;
						nxt_s.cnt = ADDR_CYCLES - 4'h1;
					end
				end
			end
			ST_ADDR: begin
				if (s_ff.cnt != 4'h0) begin
					nxt_s.cnt = s_ff.cnt - 4'h1;
				end else if (muxed) begin
					nxt_s.st = ST_ALEHI;
					nxt_s.cnt = {2'b00, s_ff.aleW};
				end else begin
					nxt_s.st = setupSt;
					nxt_s.cnt = setupCnt;
				end
			end
			ST_ALEHI: begin
				nxt_s.cnt = s_ff.cnt - 4'h1;
				if (s_ff.cnt == 4'h0) begin
					nxt_s.st = ST_ALELO;
					nxt_s.cnt = {2'b00, s_ff.aleW};
				end
			end
			ST_ALELO, ST_SETUP: begin
				nxt_s.cnt = s_ff.cnt - 4'h1;
				if (s_ff.cnt == 4'h0) begin
					if (s_ff.st == ST_ALELO) begin
						nxt_s.st = setupSt;
						nxt_s.cnt = setupCnt;
					end else begin
						nxt_s.st = ST_STROBE;
						nxt_s.cnt = ewr;
					end
				end
			end
			ST_STROBE: begin
				nxt_s.cnt = s_ff.cnt - 4'h1;
				if (s_ff.cnt == 4'h0) begin
					if (!s_ff.wr) begin
						nxt_s.rdData = busIn;
					end
					if (eah != 2'b00) begin
						nxt_s.st = ST_HOLD;
						nxt_s.cnt = {2'b00, eah - 2'b01};
					end else begin
						nxt_s.st = ST_DONE;
					end
				end
			end
			ST_HOLD: begin
				nxt_s.cnt = s_ff.cnt - 4'h1;
				if (s_ff.cnt == 4'h0) begin
					nxt_s.st = ST_DONE;
				end
			end
			ST_ONCHIP: nxt_s.st = ST_RAMWAIT;
			ST_RAMWAIT: begin
				nxt_s.rdData = ram.rdata;
				nxt_s.st = ST_DONE;
			end
			ST_FIFO: begin
				nxt_s.cnt = s_ff.cnt - 4'h1;
				if (s_ff.cnt == 4'h0) begin
					nxt_s.rdData = fifoRdData;
					nxt_s.st = ST_DONE;
				end
			end
			ST_DONE: nxt_s.st = ST_IDLE;
			default: nxt_s.st = ST_IDLE;
		endcase
		// Pin outputs follow the next state so they leave a flip-flop
		pre = (nxt_s.st == ST_ADDR) || (nxt_s.st == ST_ALEHI) || (nxt_s.st == ST_ALELO);
		nxt_s.own = pre || (nxt_s.st == ST_SETUP) || (nxt_s.st == ST_STROBE) || (nxt_s.st == ST_HOLD);
		nxt_s.ale = (nxt_s.st == ST_ALEHI);
		nxt_s.rdN = !((nxt_s.st == ST_STROBE) && !nxt_s.wr);
		nxt_s.wrN = !((nxt_s.st == ST_STROBE) && nxt_s.wr);
		nxt_s.hiOe = nxt_s.own && nxt_s.hiDrive;
		nxt_s.loOe = nxt_s.own && muxed == 1'b0;
		// Reads never drive the data lines once the address phase ends
		nxt_s.busOe = nxt_s.own && ((muxed && pre) || nxt_s.wr);
		nxt_s.busOut = (muxed && pre) ? nxt_s.addr[7:0] : nxt_s.wdata;
		nxt_s.done = (nxt_s.st == ST_DONE);
		nxt_s.ramReq = (nxt_s.st == ST_ONCHIP);
		nxt_s.fifoReq = (nxt_s.st == ST_FIFO) && (s_ff.st == ST_IDLE);
		nxt_s.busy = (nxt_s.st != ST_IDLE);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
			s_ff.st <= ST_IDLE;
			s_ff.fifoEn <= CFG_RST[CFG_FIFO_BIT];
			s_ff.muxSel <= CFG_RST[CFG_MUX_BIT];
			s_ff.mode <= CFG_RST[CFG_MODE_LSB +: 2];
			s_ff.aleW <= CFG_RST[CFG_ALE_LSB +: 2];
			s_ff.tim <= TIM_RST;
			s_ff.page <= PAGE_RST;
			s_ff.rdN <= 1'b1;
			s_ff.wrN <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wraps on the 4k boundary in every on-chip access
	assign ram.req = s_ff.ramReq;
	assign ram.we = s_ff.wr;
	assign ram.addr = s_ff.addr[RAM_AW-1:0];
	assign ram.wdata = s_ff.wdata;

	edm_expansion_data_ram u_expansion_data_ram (
		.mclk(mclk),
		.ram(ram)
	);

	assign sfrRdData = s_ff.sfrRd;
	assign movDone = s_ff.done;
	assign movBusy = s_ff.busy;
	assign movRdData = s_ff.rdData;
	assign fifoReq = s_ff.fifoReq;
	assign fifoWe = s_ff.wr;
	assign fifoAddr = s_ff.addr[9:0];
	assign fifoWrData = s_ff.wdata;
	assign addrHiOut = s_ff.addr[15:8];
	assign addrHiOe = s_ff.hiOe;
	assign addrLoOut = s_ff.addr[7:0];
	assign addrLoOe = s_ff.loOe;
	assign busOut = s_ff.busOut;
	assign busOe = s_ff.busOe;
	assign rdStrobeN = s_ff.rdN;
	assign wrStrobeN = s_ff.wrN;
	assign aleOut = s_ff.ale;
	assign emifOwn = s_ff.own;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_fifo_window: assert property (s_ff.st == ST_IDLE && movReq && fifoHit |=> s_ff.st == ST_FIFO ##1 !emifOwn)
		else $error("window access not sent to FIFO");
	a_onchip_mode: assert property (s_ff.st == ST_IDLE && movReq && s_ff.mode == MODE_ONCHIP |-> ##1 !emifOwn [*3])
		else $error("mode 00 reached off-chip bus");
	a_hi_undriven: assert property (s_ff.st == ST_IDLE && movReq && offHit && !fifoHit && !movWide && s_ff.mode != MODE_BANK |=> emifOwn && !addrHiOe)
		else $error("upper address driven by 8-bit move");
	a_hi_driven: assert property (s_ff.st == ST_IDLE && movReq && offHit && !fifoHit && (movWide || s_ff.mode == MODE_BANK) |=> addrHiOe && addrHiOut == $past(effAddr[15:8]))
		else $error("upper address not driven");
	a_ale_width: assert property ($rose(aleOut) && s_ff.aleW == 2'b11 |-> aleOut [*4] ##1 !aleOut [*4])
		else $error("latch strobe width wrong");
	a_nonmux_min: assert property (s_ff.st == ST_IDLE && movReq && offHit && !fifoHit && s_ff.muxSel && s_ff.tim == 8'h00 |-> ##4 movDone)
		else $error("short non-multiplexed access wrong length");
	a_mux_min: assert property (s_ff.st == ST_IDLE && movReq && offHit && !fifoHit && !s_ff.muxSel && s_ff.tim == 8'h00 && s_ff.aleW == 2'b00 |-> ##6 movDone)
		else $error("short multiplexed access wrong length");
	a_cfg_reserved: assert property ($past(sfrRdEn) && $past(sfrAddr) == CFG_ADDR |-> !sfrRdData[7] && !sfrRdData[5])
		else $error("reserved config bits read nonzero");
	a_strobe_width: assert property ($fell(rdStrobeN) && ewr == 4'h3 |-> !rdStrobeN [*4] ##1 rdStrobeN)
		else $error("read strobe width wrong");
	a_read_release: assert property (!rdStrobeN |-> !busOe && emifOwn)
		else $error("data bus driven during read");
endmodule
`default_nettype wire

// ### verilog/edm_pkg.sv
// Purpose: Shared constants and types for the external data memory interface
// Assumes: Special function register port with 8-bit addresses
// Notes: Timing counts are in system clock cycles
package edm_pkg;
	localparam logic [7:0] CFG_ADDR = 8'h85;
	localparam logic [7:0] TIM_ADDR = 8'h84;
	localparam logic [7:0] PAGE_ADDR = 8'haa;
	localparam logic [7:0] CFG_RST = 8'h03;
	localparam logic [7:0] TIM_RST = 8'hff;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam int CFG_FIFO_BIT = 6;
	localparam int CFG_MUX_BIT = 4;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_ALE_LSB = 0;
	localparam int TIM_EAS_LSB = 6;
	localparam int TIM_EWR_LSB = 2;
	localparam int TIM_EAH_LSB = 0;
	localparam int RAM_AW = 12;
	localparam logic [5:0] FIFO_PAGE_HI = 6'h01;
	localparam logic [1:0] MODE_ONCHIP = 2'b00;
	localparam logic [1:0] MODE_SPLIT = 2'b01;
	localparam logic [1:0] MODE_BANK = 2'b10;
	localparam logic [1:0] MODE_OFFCHIP = 2'b11;
	localparam logic [3:0] ADDR_CYCLES = 4'h2;
	localparam logic [3:0] FIFO_WAIT = 4'h2;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ALEHI, ST_ALELO, ST_SETUP, ST_STROBE, ST_HOLD,
		ST_ONCHIP, ST_RAMWAIT, ST_FIFO, ST_DONE
	} edm_state_t;
endpackage

// ### verilog/edm_ram_if.sv
// Purpose: Link between the access sequencer and the on-chip data RAM
// Assumes: Read data appear one clock after the request
// Notes: Sequencer drives, memory answers
`timescale 1ns/100ps
`default_nettype none
interface edm_ram_if;
	logic req;
	logic we;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctl (output req, output we, output addr, output wdata, input rdata);
	modport mem (input req, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### verilog/edm_expansion_data_ram.sv
// Purpose: On-chip expansion data RAM, 4k bytes
// Assumes: Single port, synchronous write and read
// Notes: Read data held in a register
`timescale 1ns/100ps
`default_nettype none
module edm_expansion_data_ram (
	// Clock
	input wire logic mclk,
	// Access
	edm_ram_if.mem ram
);
	logic [7:0] mem [0:4095];
	logic [7:0] rdata_ff;

	always_ff @(posedge mclk) begin
		if (ram.req && ram.we) begin
			mem[ram.addr] <= ram.wdata;
		end
		if (ram.req) begin
			rdata_ff <= mem[ram.addr];
		end
	end
	assign ram.rdata = rdata_ff;
endmodule
`default_nettype wire

// ### sim/edm_offchip_mem.sv
// Purpose: Off-chip byte memory on the external bus
// Assumes: Address latch is open while ale is high
// Notes: Read data may lag the strobe by a set count
`timescale 1ns/100ps
`default_nettype none
module edm_offchip_mem (
	// Clock
	input wire logic mclk,
	// Address pins
	input wire logic [7:0] hi,
	input wire logic hiOe,
	input wire logic [7:0] lo,
	input wire logic loOe,
	// Data and strobes
	input wire logic [7:0] bus,
	output logic [7:0] busIn,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic ale,
	// Port latch level and read delay
	input wire logic [7:0] park,
	input wire logic [3:0] slow
);
	logic [7:0] mem [0:65535];
	logic [7:0] latchLo = 8'h00;
	logic [7:0] junk = 8'h00;
	logic [3:0] lowCnt = 4'h0;
	logic [15:0] a;
	////////////////////////////////////////
	always @* if (ale) latchLo = bus;
	// Undriven high lines fall back to the port latch
	assign a = {hiOe ? hi : park, loOe ? lo : latchLo};
	always @(posedge mclk) begin
		junk <= junk + 8'h5b;
		lowCnt <= rdN ? 4'h0 : lowCnt + 4'h1;
		if (!wrN) mem[a] <= bus;
	end
	// Stale data must not linger on a released bus
	assign busIn = (!rdN && lowCnt >= slow) ? mem[a] : junk;
endmodule
`default_nettype wire

// ### sim/test_edm_external_bus_interface.sv
// Purpose: Self-checking bench for the external move steering
// Assumes: Memory model and FIFO stand-in answer in time
// Notes: Every FIFO, mux and mode setting swept twice with random latch width and timing, each write read back
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("mismatch at %0t: %h vs %h", $time, g, e); end end
module test_edm_external_bus_interface;
	import edm_pkg::*;
	logic mclk = 0, rst_n = 0, sfrWrEn = 0, sfrRdEn = 0, movReq = 0, movWrite = 0, movWide = 0;
	logic [7:0] sfrAddr = 0, sfrWrData = 0, indexReg = 0, movWrData = 0, fifoRdData = 0, park = 0;
	logic [15:0] dataPtr = 0;
	logic [3:0] slow = 0;
	logic [7:0] sfrRdData, movRdData, fifoWrData, addrHiOut, addrLoOut, busOut, busIn, cfg, tim, page;
	logic movDone, movBusy, fifoReq, fifoWe, addrHiOe, addrLoOe, busOe, rdStrobeN, wrStrobeN, aleOut, emifOwn;
	logic [9:0] fifoAddr, fa = 0;
	logic [7:0] fifoMem [0:1023];
	logic fq = 0;
	int mismatches = 0, checked = 0;
	edm_external_bus_interface edm_external_bus_interface_i (.mclk, .rst_n, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
		.movReq, .movWrite, .movWide, .dataPtr, .indexReg, .movWrData, .movDone, .movBusy, .movRdData,
		.fifoReq, .fifoWe, .fifoAddr, .fifoWrData, .fifoRdData, .addrHiOut, .addrHiOe, .addrLoOut,
		.addrLoOe, .busOut, .busOe, .busIn, .rdStrobeN, .wrStrobeN, .aleOut, .emifOwn);
	edm_offchip_mem edm_offchip_mem_i (.mclk, .hi(addrHiOut), .hiOe(addrHiOe), .lo(addrLoOut),
		.loOe(addrLoOe), .bus(busOut), .busIn, .rdN(rdStrobeN), .wrN(wrStrobeN), .ale(aleOut), .park, .slow);
	initial forever #25 mclk = ~mclk;
	// FIFO stand-in, answers one cycle after the request
	always @(posedge mclk) begin
		fq <= fifoReq;
		fa <= fifoAddr;
		if (fifoReq && fifoWe) fifoMem[fifoAddr] <= fifoWrData;
	end
	always @(negedge mclk) fifoRdData <= fq ? fifoMem[fa] : 8'($urandom);
	////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic sfr(input logic w, input logic [7:0] a, d, output logic [7:0] r);
		@(negedge mclk);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = w;
		sfrRdEn = !w;
		@(negedge mclk);
		sfrWrEn = 0;
		sfrRdEn = 0;
		r = sfrRdData;
	endtask
	task automatic mov(input logic w, wd, input logic [15:0] dp, input logic [7:0] ix, d, output logic [7:0] r);
		logic [15:0] ea;
		logic off, fifo, hiDrv, mux;
		int k, ale, stb, tot;
		ea = wd ? dp : {page, ix};
		fifo = cfg[6] && ea[15:10] == 6'h01;
		off = !fifo && (cfg[3:2] == 2'b11 || (cfg[3:2] != 2'b00 && ea >= 16'h1000));
		hiDrv = wd || cfg[3:2] == 2'b10;
		mux = !cfg[4];
		tot = tim[7:6] + tim[5:2] + tim[1:0] + 5 + (mux ? 2 * (cfg[1:0] + 1) : 0);
		ale = 0;
		stb = 0;
		@(negedge mclk);
		movWrite = w;
		movWide = wd;
		dataPtr = dp;
		indexReg = ix;
		movWrData = d;
		movReq = 1;
		@(negedge mclk);
		movReq = 0;
		for (k = 1; k < 60 && movDone !== 1'b1; k++) begin
			`CHK(emifOwn, off)
			`CHK(movBusy, 1'b1)
			if (emifOwn) `CHK(addrHiOe, hiDrv)
			if (emifOwn) `CHK(addrLoOe, !mux)
			if (addrHiOe) `CHK(addrHiOut, ea[15:8])
			if (addrLoOe) `CHK(addrLoOut, ea[7:0])
			if (aleOut) `CHK({busOe, busOut}, {1'b1, ea[7:0]})
			if (!rdStrobeN || !wrStrobeN) `CHK(busOe, w)
			if (!wrStrobeN) `CHK(busOut, d)
			ale += aleOut;
			stb += !rdStrobeN || !wrStrobeN;
			@(negedge mclk);
		end
		`CHK(movDone, 1'b1)
		if (off) `CHK(k + 1, tot)
		if (off) `CHK(stb, tim[5:2] + 1)
		if (off) `CHK(ale, mux ? cfg[1:0] + 1 : 0)
		if (w && off) `CHK(edm_offchip_mem_i.mem[{hiDrv ? ea[15:8] : park, ea[7:0]}], d)
		if (w && fifo) `CHK(fifoMem[ea[9:0]], d)
		`CHK(emifOwn, 1'b0)
		r = movRdData;
	endtask
	////////////////////////////////////////
	initial begin
		#2500000;
		mismatches++;
		finish_test;
	end
	initial begin
		logic [7:0] v, ix, d;
		logic [15:0] dp;
		logic wd;
		int m;
		v = 8'($urandom(32'hace16ef2));
		repeat (20) @(negedge mclk);
		rst_n = 1;
		sfr(0, CFG_ADDR, 0, v);
		`CHK(v, 8'h03)
		sfr(0, TIM_ADDR, 0, v);
		`CHK(v, 8'hff)
		sfr(1, CFG_ADDR, 8'hff, v);
		sfr(0, CFG_ADDR, 0, v);
		`CHK(v, 8'h5f)
		sfr(1, 8'h86, 8'h55, v);
		sfr(0, 8'h86, 0, v);
		`CHK(v, 8'h00)
		for (m = 0; m < 32; m++) begin
			cfg = {1'b0, m[3], 1'b0, m[2], m[1:0], 2'($urandom)};
			tim = 8'($urandom);
			park = 8'($urandom);
			slow = 4'($urandom % (tim[5:2] + 1));
			sfr(1, CFG_ADDR, cfg, v);
			sfr(1, TIM_ADDR, tim, v);
			repeat (4) begin
				wd = 1'($urandom);
				dp = 16'($urandom) & ($urandom % 2 ? 16'h0fff : 16'hffff);
				page = dp[15:8];
				ix = dp[7:0];
				d = 8'($urandom);
				sfr(1, PAGE_ADDR, page, v);
				mov(1, wd, dp, ix, d, v);
				// Mode 00 16-bit moves with the FIFO off read back through an alias
				mov(0, wd, dp ^ (wd && cfg[3:2] == 2'b00 && !cfg[6] ? 16'h3000 : 16'h0), ix, 8'h00, v);
				`CHK(v, d)
			end
			$display("config %h timing %h done", cfg, tim);
		end
		finish_test;
	end
endmodule
`default_nettype wire
